// [logic/fhcr_regs.sv]
// Frame handler configuration register bank with APB slave and cycle timer.
// Assumes a frame handler and serial transmitter beside it report idle and received data.
// Overview of operation
// - Serial data read returns last received byte; write sends the byte.
// - Writing reset bit one resets frame handler and cycle counter.
// - Reset or skip written one leaves lower six control bits unchanged.
// - Writing skip one resets frame handler but keeps cycle counter running.
// - Skip written zero while frame handler busy triggers frame handler reset.
// - Control bit 5 enables automatic checksum; resets to zero.
// - Control bit 4 enables internal synchronisation.
// - Control bit 3 enables external synchronisation.
// - Bits 2:1 select which transmit lane is the sync source.
// - Bit 0 picks sync edge: zero falling, one rising.
// - On-request length is six bits, upper bits reserved, resets to one.
// - Any length write while frame handler busy triggers frame handler reset.
// - Master process length holds bytes per master message, zero to 32.
// - Process length writes of 33 to 63 are discarded.
// - Device process length holds bytes per device message, zero to 32.
// - Base field picks 100us/none, 400us/6.4ms, or 1.6ms/32ms.
// - Smallest base with multiplier zero disables the cycle timer.
// - Cycle write with reserved base code is ignored entirely.
// - Cycle period equals offset plus base times multiplier.
//
// Added by the designer: the APB slave port.
module fhcr_regs
  import fhcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_handler_idle,
  input wire logic [7:0] serial_rx_data,
  input wire logic serial_rx_valid,
  output logic [7:0] serial_tx_data,
  output logic serial_tx_start,
  input wire logic [3:0] tx_lanes,
  output logic frame_handler_reset,
  output logic crc_enable,
  output logic internal_sync_enable,
  output logic external_sync_enable,
  output logic [1:0] sync_lane_select,
  output logic sync_edge_select,
  output logic sync_event,
  output logic [5:0] on_request_byte_count,
  output logic [5:0] master_process_byte_count,
  output logic [5:0] device_process_byte_count,
  output logic [1:0] cycle_base,
  output logic [5:0] cycle_multiplier,
  output logic cycle_timer_enable,
  output logic cycle_tick
);

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef enum logic [1:0] {FHCR_IDLE = 2'b00, FHCR_ACCESS = 2'b01} fhcr_phase_t;

  typedef struct packed {
    fhcr_phase_t phase;
    logic [31:0] rdata;
    logic err;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic tx_start;
    logic fh_reset;
    logic [5:0] ctl_cfg;
    logic [5:0] on_req;
    logic [5:0] mp_len;
    logic [5:0] dp_len;
    logic [7:0] cyc;
    logic [CNT_W-1:0] cyc_cnt;
    logic tick;
    logic sync_prev;
    logic sync_pulse;
  } fhcr_state_t;

  fhcr_state_t st;
  fhcr_state_t next_st;

  logic [7:0] widx;
  logic wr_fire;
  logic rd_fire;
  logic mapped;
  logic lane_now;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] base_cyc;
  logic [CNT_W-1:0] ofs_cyc;

  ////////////////////////////////////////////////////////////////////////
  // Decode; access phase always lasts one cycle
  assign widx = paddr[ADDR_LSB+7:ADDR_LSB];
  assign mapped = (widx >= IDX_SERIAL) && (widx <= IDX_CYCLE) && (paddr[ADDR_LSB-1:0] == 2'b00);
  assign wr_fire = psel && penable && pwrite && pready && mapped && pstrb[0];
  assign rd_fire = psel && penable && !pwrite && pready && mapped;

  // Period select; base and offset in clocks
  always_comb begin
    base_cyc = CNT_W'(BASE_SMALL_CYC);
    ofs_cyc = '0;
    case (st.cyc[CYC_BASE_HI:CYC_BASE_LO])
      BASE_MID: begin
        base_cyc = CNT_W'(BASE_MID_CYC);
        ofs_cyc = CNT_W'(OFS_MID_CYC);
      end
      BASE_LARGE: begin
        base_cyc = CNT_W'(BASE_LARGE_CYC);
        ofs_cyc = CNT_W'(OFS_LARGE_CYC);
      end
      default: begin
        base_cyc = CNT_W'(BASE_SMALL_CYC);
        ofs_cyc = '0;
      end
    endcase
  end
  // Widest product 1600us*25*63 plus 32ms fits 24 bits
  assign period = CNT_W'(ofs_cyc + base_cyc * CNT_W'(st.cyc[5:0]));
  assign lane_now = tx_lanes[st.ctl_cfg[CTL_LANE_HI:CTL_LANE_LO]];

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    next_st.tx_start = 1'b0;
    next_st.fh_reset = 1'b0;
    next_st.tick = 1'b0;
    next_st.sync_pulse = 1'b0;
    next_st.sync_prev = lane_now;
    // Received byte capture
    if (serial_rx_valid) begin
      next_st.rx_byte = serial_rx_data;
    end
    // Sync edge detect on selected lane, only when external sync on
    if (st.ctl_cfg[CTL_EXT_SYNC]) begin
      next_st.sync_pulse = st.ctl_cfg[CTL_EDGE] ? (lane_now && !st.sync_prev) : (!lane_now && st.sync_prev);
    end
    // APB phase tracking
    case (st.phase)
      FHCR_IDLE: begin
        if (psel && !penable) begin
          next_st.phase = FHCR_ACCESS;
        end
      end
      FHCR_ACCESS: begin
        next_st.phase = FHCR_IDLE;
      end
      default: begin
        next_st.phase = FHCR_IDLE;
      end
    endcase
    // Read data captured at setup for a registered answer
    if (psel && !penable) begin
      next_st.err = !((widx >= IDX_SERIAL) && (widx <= IDX_CYCLE));
      case (widx)
        IDX_SERIAL: next_st.rdata = {24'h00_0000, st.rx_byte};
        IDX_CONTROL: next_st.rdata = {24'h00_0000, 2'b00, st.ctl_cfg};
        IDX_ON_REQ: next_st.rdata = {24'h00_0000, 2'b00, st.on_req};
        IDX_MASTER_PD: next_st.rdata = {24'h00_0000, 2'b00, st.mp_len};
        IDX_DEVICE_PD: next_st.rdata = {24'h00_0000, 2'b00, st.dp_len};
        IDX_CYCLE: next_st.rdata = {24'h00_0000, st.cyc};
        default: next_st.rdata = WORD_ZERO;
      endcase
    end
    // Cycle counter; free run while enabled
    if (st.cyc != CYC_RESET) begin
      if (st.cyc_cnt + 1'b1 >= period) begin
        next_st.cyc_cnt = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.cyc_cnt = st.cyc_cnt + 1'b1;
      end
    end else begin
      next_st.cyc_cnt = '0;
    end
    // Register writes
    if (wr_fire) begin
      case (widx)
        IDX_SERIAL: begin
          next_st.tx_byte = pwdata[7:0];
          next_st.tx_start = 1'b1;
        end
        IDX_CONTROL: begin
          if (pwdata[CTL_RST]) begin
            next_st.fh_reset = 1'b1;
            next_st.cyc_cnt = '0;
          end else if (pwdata[CTL_SKIP]) begin
            next_st.fh_reset = 1'b1;
          end else begin
            next_st.ctl_cfg = pwdata[5:0];
            next_st.fh_reset = !frame_handler_idle;
          end
        end
        IDX_ON_REQ: begin
          next_st.on_req = pwdata[5:0];
          next_st.fh_reset = !frame_handler_idle;
        end
        IDX_MASTER_PD: begin
          if (pwdata[5:0] <= PD_LEN_MAX) begin
            next_st.mp_len = pwdata[5:0];
          end
          next_st.fh_reset = !frame_handler_idle;
        end
        IDX_DEVICE_PD: begin
          if (pwdata[5:0] <= PD_LEN_MAX) begin
            next_st.dp_len = pwdata[5:0];
          end
          next_st.fh_reset = !frame_handler_idle;
        end
        IDX_CYCLE: begin
          if (pwdata[CYC_BASE_HI:CYC_BASE_LO] != BASE_RSVD) begin
            next_st.cyc = pwdata[7:0];
            next_st.cyc_cnt = '0;
          end
        end
        default: begin
          next_st.err = st.err;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{phase: FHCR_IDLE, rdata: WORD_ZERO, err: 1'b0, rx_byte: BYTE_ZERO, tx_byte: BYTE_ZERO,
              tx_start: 1'b0, fh_reset: 1'b0, ctl_cfg: CTL_CFG_RESET, on_req: ON_REQ_RESET,
              mp_len: PD_LEN_RESET, dp_len: PD_LEN_RESET, cyc: CYC_RESET, cyc_cnt: '0, tick: 1'b0,
              sync_prev: 1'b0, sync_pulse: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign pready = (st.phase == FHCR_ACCESS);
  assign pslverr = pready && st.err;
  assign prdata = st.rdata;
  assign serial_tx_data = st.tx_byte;
  assign serial_tx_start = st.tx_start;
  assign frame_handler_reset = st.fh_reset;
  assign crc_enable = st.ctl_cfg[CTL_CRC];
  assign internal_sync_enable = st.ctl_cfg[CTL_INT_SYNC];
  assign external_sync_enable = st.ctl_cfg[CTL_EXT_SYNC];
  assign sync_lane_select = st.ctl_cfg[CTL_LANE_HI:CTL_LANE_LO];
  assign sync_edge_select = st.ctl_cfg[CTL_EDGE];
  assign sync_event = st.sync_pulse;
  assign on_request_byte_count = st.on_req;
  assign master_process_byte_count = st.mp_len;
  assign device_process_byte_count = st.dp_len;
  assign cycle_base = st.cyc[CYC_BASE_HI:CYC_BASE_LO];
  assign cycle_multiplier = st.cyc[5:0];
  assign cycle_timer_enable = (st.cyc != CYC_RESET);
  assign cycle_tick = st.tick;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_ctl_wr(bit b);
    wr_fire && widx == IDX_CONTROL && pwdata[CTL_RST] == b;
  endsequence

  AST_RST_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctl_wr(1'b1) |=> frame_handler_reset && st.cyc_cnt == '0) else $error("reset write missed");
  AST_KEEP_CFG: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && widx == IDX_CONTROL && (pwdata[CTL_RST] || pwdata[CTL_SKIP]) |=> $stable(st.ctl_cfg))
    else $error("config changed on strobe write");
  AST_SKIP: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctl_wr(1'b0) ##0 pwdata[CTL_SKIP] |=> frame_handler_reset) else $error("skip missed");
  AST_BUSY_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && widx >= IDX_ON_REQ && widx <= IDX_DEVICE_PD && !frame_handler_idle |=> frame_handler_reset)
    else $error("busy length write no reset");
  AST_PD_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && widx == IDX_MASTER_PD && pwdata[5:0] > PD_LEN_MAX |=> $stable(master_process_byte_count))
    else $error("oversize length stored");
  AST_CYC_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && widx == IDX_CYCLE && pwdata[CYC_BASE_HI:CYC_BASE_LO] == BASE_RSVD |=> $stable(st.cyc))
    else $error("reserved base stored");
  AST_CYC_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    st.cyc == CYC_RESET |=> !cycle_tick) else $error("tick while disabled");
  AST_CTL_READ: assert property (@(posedge pclk) disable iff (!presetn)
    rd_fire && widx == IDX_CONTROL |-> prdata[7:6] == 2'b00) else $error("strobe bits read nonzero");
  AST_LEN_READ: assert property (@(posedge pclk) disable iff (!presetn)
    rd_fire && widx == IDX_ON_REQ |-> prdata[7:6] == 2'b00) else $error("reserved bits read nonzero");
  AST_TX: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && widx == IDX_SERIAL |=> serial_tx_start && serial_tx_data == $past(pwdata[7:0]))
    else $error("serial write not sent");

  ////////////////////////////////////////////////////////////////////////
  // Further checks; counter steps follow the live period, so base changes stay covered
  sequence s_len_wr;
    wr_fire && widx >= IDX_ON_REQ && widx <= IDX_DEVICE_PD;
  endsequence
  sequence s_cyc_wr;
    wr_fire && widx == IDX_CYCLE && pwdata[CYC_BASE_HI:CYC_BASE_LO] != BASE_RSVD;
  endsequence

  // Serial port
  AST_RX_TAKE: assert property (@(posedge pclk) disable iff (!presetn)
    serial_rx_valid |=> st.rx_byte == $past(serial_rx_data))
    else $error("received byte lost");
  AST_RX_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    !serial_rx_valid |=> $stable(st.rx_byte))
    else $error("received byte changed");
  AST_RX_READ: assert property (@(posedge pclk) disable iff (!presetn)
    rd_fire && widx == IDX_SERIAL |-> prdata[7:0] == $past(st.rx_byte))
    else $error("serial read wrong");

  // Control register
  AST_CFG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctl_wr(1'b0) ##0 !pwdata[CTL_SKIP] |=> st.ctl_cfg == $past(pwdata[CTL_CRC:CTL_EDGE]))
    else $error("config not stored");
  AST_BUSY_CTL: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctl_wr(1'b0) ##0 (!pwdata[CTL_SKIP] && !frame_handler_idle) |=> frame_handler_reset)
    else $error("busy control write no reset");
  AST_IDLE_CTL: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctl_wr(1'b0) ##0 (!pwdata[CTL_SKIP] && frame_handler_idle) |=> !frame_handler_reset)
    else $error("idle control write reset");
  AST_SKIP_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctl_wr(1'b0) ##0 (pwdata[CTL_SKIP] && cycle_timer_enable && st.cyc_cnt + 1'b1 < period)
    |=> st.cyc_cnt == $past(st.cyc_cnt) + 1'b1)
    else $error("skip moved cycle counter");

  // Length registers
  AST_OD_SET: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && widx == IDX_ON_REQ |=> on_request_byte_count == $past(pwdata[5:0]))
    else $error("on request length lost");
  AST_MP_SET: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && widx == IDX_MASTER_PD && pwdata[5:0] <= PD_LEN_MAX |=> st.mp_len == $past(pwdata[5:0]))
    else $error("master length lost");
  AST_DP_SET: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && widx == IDX_DEVICE_PD && pwdata[5:0] <= PD_LEN_MAX |=> st.dp_len == $past(pwdata[5:0]))
    else $error("device length lost");
  AST_DP_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && widx == IDX_DEVICE_PD && pwdata[5:0] > PD_LEN_MAX |=> $stable(st.dp_len))
    else $error("oversize device length");
  AST_IDLE_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    s_len_wr ##0 frame_handler_idle |=> !frame_handler_reset)
    else $error("idle length write reset");
  AST_FHR_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
    frame_handler_reset |-> $past(wr_fire))
    else $error("reset with no write");
  AST_PD_READ: assert property (@(posedge pclk) disable iff (!presetn)
    rd_fire && (widx == IDX_MASTER_PD || widx == IDX_DEVICE_PD) |-> prdata[7:6] == 2'b00)
    else $error("reserved bits read nonzero");

  // Cycle timer
  AST_CYC_SET: assert property (@(posedge pclk) disable iff (!presetn)
    s_cyc_wr |=> {cycle_base, cycle_multiplier} == $past(pwdata[7:0]) && st.cyc_cnt == '0)
    else $error("cycle setting lost");
  AST_CNT_BOUND: assert property (@(posedge pclk) disable iff (!presetn)
    cycle_timer_enable |-> st.cyc_cnt < period)
    else $error("counter past period");
  AST_CNT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    cycle_timer_enable && !wr_fire && st.cyc_cnt + 1'b1 < period |=> st.cyc_cnt == $past(st.cyc_cnt) + 1'b1)
    else $error("counter skipped");
  AST_TICK_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    cycle_timer_enable && !wr_fire && st.cyc_cnt + 1'b1 == period |=> cycle_tick && st.cyc_cnt == '0)
    else $error("period end missed");

  // Sync edges on the chosen lane
  AST_SYNC_RISE: assert property (@(posedge pclk) disable iff (!presetn)
    external_sync_enable && sync_edge_select && $rose(lane_now) |=> sync_event)
    else $error("rising sync missed");
  AST_SYNC_FALL: assert property (@(posedge pclk) disable iff (!presetn)
    external_sync_enable && !sync_edge_select && $fell(lane_now) |=> sync_event)
    else $error("falling sync missed");
  AST_SYNC_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !external_sync_enable |=> !sync_event)
    else $error("sync while disabled");
  AST_SYNC_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
    sync_event |-> $past(lane_now) != $past(lane_now, 2))
    else $error("sync with no edge");

endmodule : fhcr_regs

// [logic/fhcr_pkg.sv]
// Constants for the frame handler configuration register bank.
// Assumes an APB master with 32-bit data; registers sit in the low byte.
package fhcr_pkg;
  // Printed offsets are not multiples of four, so they are word indices
  localparam logic [7:0] IDX_SERIAL = 8'h84;
  localparam logic [7:0] IDX_CONTROL = 8'h85;
  localparam logic [7:0] IDX_ON_REQ = 8'h86;
  localparam logic [7:0] IDX_MASTER_PD = 8'h87;
  localparam logic [7:0] IDX_DEVICE_PD = 8'h88;
  localparam logic [7:0] IDX_CYCLE = 8'h89;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_W = 12;
  // Control register fields
  localparam int CTL_RST = 7;
  localparam int CTL_SKIP = 6;
  localparam int CTL_CRC = 5;
  localparam int CTL_INT_SYNC = 4;
  localparam int CTL_EXT_SYNC = 3;
  localparam int CTL_LANE_HI = 2;
  localparam int CTL_LANE_LO = 1;
  localparam int CTL_EDGE = 0;
  localparam logic [5:0] CTL_CFG_RESET = 6'h00;
  // Length fields
  localparam logic [5:0] ON_REQ_RESET = 6'h01;
  localparam logic [5:0] PD_LEN_RESET = 6'h00;
  localparam logic [5:0] PD_LEN_MAX = 6'h20;
  // Cycle time fields and codes
  localparam int CYC_BASE_HI = 7;
  localparam int CYC_BASE_LO = 6;
  localparam logic [1:0] BASE_SMALL = 2'b00;
  localparam logic [1:0] BASE_MID = 2'b01;
  localparam logic [1:0] BASE_LARGE = 2'b10;
  localparam logic [1:0] BASE_RSVD = 2'b11;
  localparam logic [7:0] CYC_RESET = 8'h00;
  localparam logic [5:0] CYCLE_MULTIPLIER_ZERO = 6'h00;
  // Times in microseconds and cycles at 25 MHz
  localparam int CLK_MHZ = 25;
  localparam int BASE_SMALL_US = 100;
  localparam int BASE_MID_US = 400;
  localparam int BASE_LARGE_US = 1600;
  localparam int OFS_MID_US = 6400;
  localparam int OFS_LARGE_US = 32000;
  localparam int BASE_SMALL_CYC = BASE_SMALL_US * CLK_MHZ;
  localparam int BASE_MID_CYC = BASE_MID_US * CLK_MHZ;
  localparam int BASE_LARGE_CYC = BASE_LARGE_US * CLK_MHZ;
  localparam int OFS_MID_CYC = OFS_MID_US * CLK_MHZ;
  localparam int OFS_LARGE_CYC = OFS_LARGE_US * CLK_MHZ;
  localparam int CNT_W = 24;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage : fhcr_pkg

// [test/fhcr_far_model.sv]
// Far side model: frame handler status, receiver and sync lanes.
// Assumes the bench steers it by plain levels on the pclk domain.
module fhcr_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic busy,
  input wire logic rx_go,
  input wire logic [7:0] rx_byte,
  input wire logic [3:0] lanes,
  output logic frame_handler_idle,
  output logic [7:0] serial_rx_data,
  output logic serial_rx_valid,
  output logic [3:0] tx_lanes
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  // Idle level and lanes pass straight through
  assign frame_handler_idle = !busy;
  assign tx_lanes = lanes;
  // Byte is only valid with its pulse; otherwise scrambled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_rx_valid <= 1'b0;
      serial_rx_data <= 8'h00;
    end else begin
      serial_rx_valid <= rx_go;
      serial_rx_data <= rx_go ? rx_byte : ~serial_rx_data;
    end
  end
endmodule : fhcr_far_model

// [test/testbench.sv]
// Register bank bench: APB tasks and sequenced checks.
// Assumes an APB slave that answers within 16 cycles, and the far side model.
module testbench
  import fhcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, busy, rx_go, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, lanes, tx_lanes;
  logic pready, pslverr, frame_handler_idle, serial_rx_valid, serial_tx_start, frame_handler_reset;
  logic crc_enable, internal_sync_enable, external_sync_enable, sync_edge_select, sync_event;
  logic cycle_timer_enable, cycle_tick, ebit;
  logic [7:0] rx_byte, serial_rx_data, serial_tx_data, q;
  logic [1:0] sync_lane_select, cycle_base;
  logic [5:0] on_request_byte_count, master_process_byte_count, device_process_byte_count, cycle_multiplier;
  logic [7:0] stb [2] = '{8'h80, 8'h40};
  logic [7:0] lidx [3] = '{IDX_ON_REQ, IDX_MASTER_PD, IDX_DEVICE_PD};
  logic [7:0] cyc_code [2] = '{8'h41, 8'h81};
  int n_mismatch = 0, checks_done = 0, n_fhr = 0, n_txs = 0, n_sync = 0, n_tick = 0;
  int cyc = 0, t_prev = 0, t_last = 0, f0;
  ////////////////////////////////////////
  fhcr_regs i_fhcr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_handler_idle(frame_handler_idle), .serial_rx_data(serial_rx_data),
    .serial_rx_valid(serial_rx_valid), .serial_tx_data(serial_tx_data), .serial_tx_start(serial_tx_start),
    .tx_lanes(tx_lanes), .frame_handler_reset(frame_handler_reset), .crc_enable(crc_enable),
    .internal_sync_enable(internal_sync_enable), .external_sync_enable(external_sync_enable),
    .sync_lane_select(sync_lane_select), .sync_edge_select(sync_edge_select), .sync_event(sync_event),
    .on_request_byte_count(on_request_byte_count), .master_process_byte_count(master_process_byte_count),
    .device_process_byte_count(device_process_byte_count), .cycle_base(cycle_base),
    .cycle_multiplier(cycle_multiplier), .cycle_timer_enable(cycle_timer_enable), .cycle_tick(cycle_tick));
  fhcr_far_model i_fhcr_far_model (.pclk(pclk), .presetn(presetn), .busy(busy), .rx_go(rx_go),
    .rx_byte(rx_byte), .lanes(lanes), .frame_handler_idle(frame_handler_idle),
    .serial_rx_data(serial_rx_data), .serial_rx_valid(serial_rx_valid), .tx_lanes(tx_lanes));
  ////////////////////////////////////////
  // Clock at 25 MHz
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Pulse counters; counting hides exact pulse timing from the checks, but tick cycles are kept in t_prev and t_last
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (frame_handler_reset === 1'b1) n_fhr <= n_fhr + 1;
    if (serial_tx_start === 1'b1) n_txs <= n_txs + 1;
    if (sync_event === 1'b1) n_sync <= n_sync + 1;
    if (cycle_tick === 1'b1) begin
      t_prev <= t_last;
      t_last <= cyc;
      n_tick <= n_tick + 1;
    end
  end
  ////////////////////////////////////////
  task automatic close_out;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chkn(input string nm, input int e, input int g);
    checks_done++;
    if (g != e) begin
      n_mismatch++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chkn
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_mismatch++;
      close_out();
    end
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask : settle
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
    settle();
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string nm);
    apb(1'b0, idx, 8'h00);
    chk(nm, e, q);
  endtask : rd
  task automatic set_busy(input logic b);
    @(posedge pclk);
    busy <= b;
    f0 = n_fhr;
  endtask : set_busy
  // Bounded wait for the next cycle tick
  task automatic wait_tick;
    int i, n;
    n = n_tick;
    for (i = 0; i < 7000; i++) begin
      @(posedge pclk);
      if (n_tick != n) break;
    end
    if (i == 7000) begin
      n_mismatch++;
      close_out();
    end
    @(posedge pclk);
  endtask : wait_tick
  ////////////////////////////////////////
  // Main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    pstrb = 4'hF; busy = 1'b0; rx_go = 1'b0; rx_byte = 8'h00; lanes = 4'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_SERIAL, 8'h00, "serial");
    rd(IDX_CONTROL, 8'h00, "control");
    rd(IDX_ON_REQ, 8'h01, "on_req");
    rd(IDX_MASTER_PD, 8'h00, "master_pd");
    rd(IDX_DEVICE_PD, 8'h00, "device_pd");
    rd(IDX_CYCLE, 8'h00, "cycle");
    apb(1'b0, 8'h00, 8'h00);
    chk("unmapped error", 8'h01, {7'h00, err});
    $display("test reset done");
    @(posedge pclk);
    rx_byte <= 8'hA5;
    rx_go <= 1'b1;
    @(posedge pclk);
    rx_go <= 1'b0;
    settle();
    rd(IDX_SERIAL, 8'hA5, "serial rx");
    f0 = n_txs;
    wr(IDX_SERIAL, 8'h3C);
    chk("tx data", 8'h3C, serial_tx_data);
    chkn("tx start", f0 + 1, n_txs);
    $display("test serial done");
    wr(IDX_CONTROL, 8'h3F);
    rd(IDX_CONTROL, 8'h3F, "control");
    chk("cfg out", 8'h3F, {2'b00, crc_enable, internal_sync_enable, external_sync_enable,
      sync_lane_select, sync_edge_select});
    for (int s = 0; s < 2; s++) begin
      f0 = n_fhr;
      wr(IDX_CONTROL, stb[s]);
      chkn("strobe reset", f0 + 1, n_fhr);
      rd(IDX_CONTROL, 8'h3F, "control kept");
    end
    set_busy(1'b1);
    wr(IDX_CONTROL, 8'h15);
    chkn("busy reset", f0 + 1, n_fhr);
    rd(IDX_CONTROL, 8'h15, "control");
    set_busy(1'b0);
    wr(IDX_CONTROL, 8'h2A);
    chkn("idle no reset", f0, n_fhr);
    $display("test control done");
    // Every lane and both edges; a neighbour lane must not trigger
    for (int l = 0; l < 4; l++) begin
      for (int e = 0; e < 2; e++) begin
        ebit = e[0];
        lanes <= ebit ? 4'h0 : 4'hF;
        wr(IDX_CONTROL, 8'(8'h08 | (l << 1) | e));
        f0 = n_sync;
        lanes[(l + 1) % 4] <= ebit;
        settle();
        lanes[l] <= ebit;
        settle();
        lanes[l] <= ~ebit;
        settle();
        chkn("sync event", f0 + 1, n_sync);
      end
    end
    wr(IDX_CONTROL, 8'h00);
    f0 = n_sync;
    lanes <= 4'hF;
    settle();
    lanes <= 4'h0;
    settle();
    chkn("sync off", f0, n_sync);
    $display("test sync done");
    for (int r = 0; r < 3; r++) begin
      wr(lidx[r], 8'hDF);
      rd(lidx[r], 8'h1F, "length");
      wr(lidx[r], 8'h20);
      rd(lidx[r], 8'h20, "length max");
      if (r > 0) begin
        wr(lidx[r], 8'h21);
        rd(lidx[r], 8'h20, "length kept");
      end
      set_busy(1'b1);
      wr(lidx[r], 8'h05);
      chkn("length busy", f0 + 1, n_fhr);
      set_busy(1'b0);
    end
    chk("on request count", 8'h05, {2'b00, on_request_byte_count});
    chk("master count", 8'h05, {2'b00, master_process_byte_count});
    chk("device count", 8'h05, {2'b00, device_process_byte_count});
    $display("test length done");
    wr(IDX_CYCLE, 8'hC5);
    rd(IDX_CYCLE, 8'h00, "cycle rsvd");
    chk("timer off", 8'h00, {7'h00, cycle_timer_enable});
    for (int c = 0; c < 2; c++) begin
      wr(IDX_CYCLE, cyc_code[c]);
      rd(IDX_CYCLE, cyc_code[c], "cycle");
      chk("cycle fields", cyc_code[c], {cycle_base, cycle_multiplier});
      chk("timer on", 8'h01, {7'h00, cycle_timer_enable});
    end
    wr(IDX_CYCLE, 8'hC7);
    rd(IDX_CYCLE, 8'h81, "cycle kept");
    wr(IDX_CYCLE, 8'h00);
    chk("timer off", 8'h00, {7'h00, cycle_timer_enable});
    // Two times the 100 us base is 5000 clocks at 25 MHz
    wr(IDX_CYCLE, 8'h02);
    wait_tick();
    wait_tick();
    chkn("period", 5000, t_last - t_prev);
    repeat (1000) @(posedge pclk);
    wr(IDX_CONTROL, 8'h40);
    wait_tick();
    chkn("skip period", 5000, t_last - t_prev);
    repeat (1000) @(posedge pclk);
    wr(IDX_CONTROL, 8'h80);
    wait_tick();
    chkn("restart", 1, int'(t_last - t_prev > 5000));
    $display("test cycle done");
    close_out();
  end
endmodule : testbench
